/* File: rtl/rtd_regs.svh */
`ifndef RTD_REGS_SVH
`define RTD_REGS_SVH
// Register byte offsets
`define RTD_OFS_CMD     5'h00
`define RTD_OFS_ARG0    5'h04
`define RTD_OFS_ARG1    5'h08
`define RTD_OFS_STATUS  5'h0C
`define RTD_OFS_RESP    5'h10
`define RTD_OFS_DIR     5'h14
// Command word fields
`define RTD_CMD_OP_LSB   0
`define RTD_CMD_MASK_LSB 4
`define RTD_CMD_AXIS_LSB 8
`define RTD_CMD_TBL_LSB  12
`define RTD_CMD_IDX_LSB  16
// Status word fields
`define RTD_ST_BUSY      0
`define RTD_ST_OPEN      1
`define RTD_ST_TBL_LSB   2
`define RTD_ST_REFUSED   5
`define RTD_ST_EMPTY     6
`define RTD_ST_VALID     7
// Reset values and limits
`define RTD_DECEL_RST   23'h03_0D40
`define RTD_ACCEL_RST   23'h03_0D40
`define RTD_RATE_MAX    23'h7A_1200
`define RTD_FRAC_ONE    16'h8000
`define RTD_MAX_PTS     5'h19
`define RTD_TABLES      3'h4
`endif

/* File: rtl/rtd_pkg.sv */
package rtd_pkg;
  typedef enum logic [3:0] {
    OP_NOP        = 4'h0,
    OP_TBL_BEGIN  = 4'h1,
    OP_BKPT_DEF   = 4'h2,
    OP_TBL_END    = 4'h3,
    OP_ENTRY_Q    = 4'h4,
    OP_SIZE_Q     = 4'h5,
    OP_DIR_INVERT = 4'h6,
    OP_DIR_NORMAL = 4'h7,
    OP_DIR_Q      = 4'h8,
    OP_DECEL_SET  = 4'h9,
    OP_ACCEL_SET  = 4'hA,
    OP_DECEL_Q    = 4'hB,
    OP_ASYM_GO    = 4'hC,
    OP_MOVE_GO    = 4'hD
  } rtd_op_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_MEM  = 2'b11
  } rtd_state_type;
endpackage

/* File: rtl/rtd_mem_if.sv */
`timescale 1ns/1ps
interface rtd_mem_if #(parameter int AW = 7, parameter int DW = 32);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctl (output we, waddr, wdata, raddr, input rdata);
  modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface

/* File: rtl/rtd_ramp_mem.sv */
`timescale 1ns/1ps
module rtd_ramp_mem #(
  parameter int AW = 7,
  parameter int DW = 32
) (
  input  wire logic I_REF_CLK, // Clock
  rtd_mem_if.mem    bus        // Table storage port
);
  logic [DW-1:0] mem_q [2**AW];
  logic [DW-1:0] rdata_ff;

  // No reset: contents only matter below each table's stored size
  always_ff @(posedge I_REF_CLK) begin
    if (bus.we) begin
      mem_q[bus.waddr] <= bus.wdata;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    rdata_ff <= mem_q[bus.raddr];
  end

  assign bus.rdata = rdata_ff;
endmodule // rtd_ramp_mem

/* File: rtl/rtd_ramp_dir_decel.sv */
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`include "rtd_regs.svh"
// Function
// - At most 25 breakpoints per table
// - Breakpoint fractions 0.0 to 1.0, accel then velocity
// - End command closes the open definition
// - Begin takes table 1..4, replaces old table
// - While open only breakpoint and end accepted
// - Entry query returns breakpoint, or empty marker
// - Direction low positive, high negative by default
// - Invert sets inverted direction polarity of addressed axes
// - Normalize restores default polarity of addressed axes
// - Clear mask bit leaves that axis unchanged
// - Polarity query reports normal or inverted
// - Decel rate used only by asymmetric start
// - Decel resets to 200000, follows accel set
// - Decel rate limited to 1..8000000
// - Decel query returns rate of asymmetric start
// - Size query returns stored breakpoint count
module rtd_ramp_dir_decel #(
  parameter int AXES   = 4,
  parameter int RATE_W = 23,
  parameter int FRAC_W = 16
) (
  input  wire logic              I_REF_CLK,          // 40 MHz clock
  input  wire logic              I_SRST,             // Sync reset, high
  input  wire logic [4:0]        I_AVS_ADDRESS,      // Byte address
  input  wire logic              I_AVS_READ,         // Read request
  input  wire logic              I_AVS_WRITE,        // Write request
  input  wire logic [31:0]       I_AVS_WRITEDATA,    // Write data
  input  wire logic [3:0]        I_AVS_BYTEENABLE,   // Byte lanes
  output logic      [31:0]       O_AVS_READDATA,     // Read data
  output logic                   O_AVS_WAITREQUEST,  // Stall
  input  wire logic [AXES-1:0]   I_AXIS_NEG,         // Axis moving negative
  output logic      [AXES-1:0]   O_DIR,              // Direction outputs
  output logic                   O_MOVE_GO,          // Move start pulse
  output logic      [1:0]        O_MOVE_AXIS,        // Axis of the move
  output logic                   O_MOVE_ASYM,        // Asymmetric start
  output logic      [RATE_W-1:0] O_MOVE_DECEL        // Ramp-down rate
);
  localparam int TW = 2;
  localparam int MAW = TW + 5;

  ////////////////////////////////////////////////////////////////
  function automatic logic tbl_ok(input logic [2:0] t);
    return (t != 3'h0) && (t <= `RTD_TABLES);
  endfunction

  function automatic logic rate_ok(input logic [31:0] r);
    return (r != 32'h0000_0000) && (r <= {9'h000, `RTD_RATE_MAX});
  endfunction

  ////////////////////////////////////////////////////////////////
  rtd_pkg::rtd_state_type state_ff;
  logic [31:0]        cmd_ff;
  logic [31:0]        arg0_ff;
  logic [31:0]        arg1_ff;
  logic [31:0]        resp_ff;
  logic [31:0]        rd_data_ff;
  logic               rd_ack_ff;
  logic               refused_ff;
  logic               resp_valid_ff;
  logic               resp_empty_ff;
  logic               def_open_ff;
  logic [2:0]         open_tbl_ff;
  logic [4:0]         pt_cnt_ff;
  logic [4:0]         size_ff [4];
  logic [AXES-1:0]    inv_ff;
  logic [AXES-1:0]    dir_ff;
  logic [RATE_W-1:0]  decel_ff [AXES];
  logic [RATE_W-1:0]  accel_ff [AXES];
  logic               go_ff;
  logic [1:0]         go_axis_ff;
  logic               go_asym_ff;
  logic [RATE_W-1:0]  go_rate_ff;

  rtd_pkg::rtd_op_type op;
  logic [AXES-1:0]     mask;
  logic [1:0]          axis;
  logic [2:0]          tbl;
  logic [1:0]          tix;
  logic [1:0]          otix;
  logic [4:0]          idx;
  logic [FRAC_W-1:0]   acc_frac;
  logic [FRAC_W-1:0]   vel_frac;
  logic                exec;
  logic                ok;
  logic                cmd_go;
  logic                wr_cmd;
  logic [31:0]         wmask;

  rtd_mem_if #(.AW(MAW), .DW(32)) mem_bus ();

  rtd_ramp_mem #(.AW(MAW), .DW(32)) u_mem (
    .I_REF_CLK (I_REF_CLK),
    .bus       (mem_bus.mem)
  );

  assign op       = rtd_pkg::rtd_op_type'(cmd_ff[`RTD_CMD_OP_LSB +: 4]);
  assign mask     = cmd_ff[`RTD_CMD_MASK_LSB +: AXES];
  assign axis     = cmd_ff[`RTD_CMD_AXIS_LSB +: 2];
  assign tbl      = cmd_ff[`RTD_CMD_TBL_LSB +: 3];
  assign idx      = cmd_ff[`RTD_CMD_IDX_LSB +: 5];
  assign tix      = 2'(tbl - 3'h1);
  assign otix     = 2'(open_tbl_ff - 3'h1);
  assign acc_frac = arg0_ff[FRAC_W-1:0];
  assign vel_frac = arg1_ff[FRAC_W-1:0];
  assign exec     = (state_ff == rtd_pkg::ST_EXEC);

  ////////////////////////////////////////////////////////////////
  // Bus slave: reads take one wait cycle so read data is registered
  assign wr_cmd = I_AVS_WRITE && (I_AVS_ADDRESS == `RTD_OFS_CMD);
  assign cmd_go = wr_cmd && (state_ff == rtd_pkg::ST_IDLE);
  assign O_AVS_WAITREQUEST = (I_AVS_READ && !rd_ack_ff) ||
                             (wr_cmd && (state_ff != rtd_pkg::ST_IDLE));
  assign O_AVS_READDATA = rd_data_ff;

  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_be
      assign wmask[gb*8 +: 8] = {8{I_AVS_BYTEENABLE[gb]}};
    end
  endgenerate

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      rd_ack_ff <= 1'b0;
    end else begin
      rd_ack_ff <= I_AVS_READ && !rd_ack_ff;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      rd_data_ff <= 32'h0000_0000;
    end else if (I_AVS_READ && !rd_ack_ff) begin
      case (I_AVS_ADDRESS)
        `RTD_OFS_CMD:    rd_data_ff <= cmd_ff;
        `RTD_OFS_ARG0:   rd_data_ff <= arg0_ff;
        `RTD_OFS_ARG1:   rd_data_ff <= arg1_ff;
        `RTD_OFS_STATUS: rd_data_ff <= {24'h00_0000, resp_valid_ff,
                                        resp_empty_ff, refused_ff, open_tbl_ff,
                                        def_open_ff, state_ff != rtd_pkg::ST_IDLE};
        `RTD_OFS_RESP:   rd_data_ff <= resp_ff;
        `RTD_OFS_DIR:    rd_data_ff <= 32'(inv_ff);
        default:         rd_data_ff <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      cmd_ff  <= 32'h0000_0000;
      arg0_ff <= 32'h0000_0000;
      arg1_ff <= 32'h0000_0000;
    end else begin
      if (cmd_go) begin
        cmd_ff <= I_AVS_WRITEDATA;
      end
      if (I_AVS_WRITE && I_AVS_ADDRESS == `RTD_OFS_ARG0) begin
        arg0_ff <= (arg0_ff & ~wmask) | (I_AVS_WRITEDATA & wmask);
      end
      if (I_AVS_WRITE && I_AVS_ADDRESS == `RTD_OFS_ARG1) begin
        arg1_ff <= (arg1_ff & ~wmask) | (I_AVS_WRITEDATA & wmask);
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Command sequencer
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      state_ff <= rtd_pkg::ST_IDLE;
    end else begin
      case (state_ff)
        rtd_pkg::ST_IDLE: if (cmd_go) state_ff <= rtd_pkg::ST_EXEC;
        rtd_pkg::ST_EXEC: begin
          if (ok && op == rtd_pkg::OP_ENTRY_Q) state_ff <= rtd_pkg::ST_MEM;
          else state_ff <= rtd_pkg::ST_IDLE;
        end
        default: state_ff <= rtd_pkg::ST_IDLE;
      endcase
    end
  end

  // Legality of the command in the execute cycle
  always_comb begin
    ok = 1'b0;
    if (def_open_ff && op != rtd_pkg::OP_BKPT_DEF && op != rtd_pkg::OP_TBL_END) begin
      ok = 1'b0;
    end else begin
      case (op)
        rtd_pkg::OP_TBL_BEGIN:  ok = tbl_ok(tbl);
        rtd_pkg::OP_BKPT_DEF:   ok = def_open_ff && (pt_cnt_ff < `RTD_MAX_PTS) &&
                                     (acc_frac <= `RTD_FRAC_ONE) &&
                                     (vel_frac <= `RTD_FRAC_ONE);
        rtd_pkg::OP_TBL_END:    ok = def_open_ff;
        rtd_pkg::OP_ENTRY_Q:    ok = tbl_ok(tbl) && (idx != 5'h00) &&
                                     (idx <= `RTD_MAX_PTS);
        rtd_pkg::OP_SIZE_Q:     ok = tbl_ok(tbl);
        rtd_pkg::OP_DECEL_SET,
        rtd_pkg::OP_ACCEL_SET:  ok = rate_ok(arg0_ff);
        rtd_pkg::OP_DIR_INVERT,
        rtd_pkg::OP_DIR_NORMAL,
        rtd_pkg::OP_DIR_Q,
        rtd_pkg::OP_DECEL_Q,
        rtd_pkg::OP_ASYM_GO,
        rtd_pkg::OP_MOVE_GO:    ok = 1'b1;
        default:                ok = 1'b0;
      endcase
    end
  end

  // Refused flag: a new refusal wins over a clear in the same cycle
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      refused_ff <= 1'b0;
    end else if (exec && !ok) begin
      refused_ff <= 1'b1;
    end else if (I_AVS_WRITE && I_AVS_ADDRESS == `RTD_OFS_STATUS &&
                 I_AVS_WRITEDATA[`RTD_ST_REFUSED]) begin
      refused_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Table definition
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      def_open_ff <= 1'b0;
      open_tbl_ff <= 3'h0;
      pt_cnt_ff   <= 5'h00;
      for (int t = 0; t < 4; t++) size_ff[t] <= 5'h00;
    end else if (exec && ok) begin
      case (op)
        rtd_pkg::OP_TBL_BEGIN: begin
          def_open_ff  <= 1'b1;
          open_tbl_ff  <= tbl;
          pt_cnt_ff    <= 5'h00;
          size_ff[tix] <= 5'h00;
        end
        rtd_pkg::OP_BKPT_DEF: begin
          pt_cnt_ff     <= pt_cnt_ff + 5'h01;
          size_ff[otix] <= pt_cnt_ff + 5'h01;
        end
        rtd_pkg::OP_TBL_END: begin
          def_open_ff <= 1'b0;
          open_tbl_ff <= 3'h0;
        end
        default: ;
      endcase
    end
  end

  // Velocity order is the host's duty and is stored unchecked
  assign mem_bus.we    = exec && ok && (op == rtd_pkg::OP_BKPT_DEF);
  assign mem_bus.waddr = {otix, pt_cnt_ff};
  assign mem_bus.wdata = {vel_frac, acc_frac};
  assign mem_bus.raddr = {tix, 5'(idx - 5'h01)};

  ////////////////////////////////////////////////////////////////
  // Query answers
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      resp_ff       <= 32'h0000_0000;
      resp_valid_ff <= 1'b0;
      resp_empty_ff <= 1'b0;
    end else if (cmd_go) begin
      resp_valid_ff <= 1'b0;
    end else if (state_ff == rtd_pkg::ST_MEM) begin
      resp_valid_ff <= 1'b1;
      resp_empty_ff <= (idx > size_ff[tix]);
      resp_ff <= (idx > size_ff[tix]) ? 32'h0000_0000 : mem_bus.rdata;
    end else if (exec && ok) begin
      resp_empty_ff <= 1'b0;
      case (op)
        rtd_pkg::OP_SIZE_Q: begin
          resp_ff       <= 32'(size_ff[tix]);
          resp_valid_ff <= 1'b1;
        end
        rtd_pkg::OP_DIR_Q: begin
          resp_ff       <= 32'(inv_ff[axis]);
          resp_valid_ff <= 1'b1;
        end
        rtd_pkg::OP_DECEL_Q: begin
          resp_ff       <= 32'(decel_ff[axis]);
          resp_valid_ff <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Direction polarity per axis
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      inv_ff <= '0;
    end else if (exec && ok && op == rtd_pkg::OP_DIR_INVERT) begin
      inv_ff <= inv_ff | mask;
    end else if (exec && ok && op == rtd_pkg::OP_DIR_NORMAL) begin
      inv_ff <= inv_ff & ~mask;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      dir_ff <= '0;
    end else begin
      dir_ff <= I_AXIS_NEG ^ inv_ff;
    end
  end

  assign O_DIR = dir_ff;

  ////////////////////////////////////////////////////////////////
  // Rates per axis
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      for (int a = 0; a < AXES; a++) begin
        decel_ff[a] <= `RTD_DECEL_RST;
        accel_ff[a] <= `RTD_ACCEL_RST;
      end
    end else if (exec && ok && op == rtd_pkg::OP_ACCEL_SET) begin
      accel_ff[axis] <= arg0_ff[RATE_W-1:0];
      decel_ff[axis] <= arg0_ff[RATE_W-1:0];
    end else if (exec && ok && op == rtd_pkg::OP_DECEL_SET) begin
      decel_ff[axis] <= arg0_ff[RATE_W-1:0];
    end
  end

  // Move start: only the asymmetric start ramps down at the decel rate
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      go_ff      <= 1'b0;
      go_axis_ff <= 2'h0;
      go_asym_ff <= 1'b0;
      go_rate_ff <= '0;
    end else begin
      go_ff <= exec && (op == rtd_pkg::OP_ASYM_GO || op == rtd_pkg::OP_MOVE_GO) && ok;
      if (exec && ok && op == rtd_pkg::OP_ASYM_GO) begin
        go_axis_ff <= axis;
        go_asym_ff <= 1'b1;
        go_rate_ff <= decel_ff[axis];
      end else if (exec && ok && op == rtd_pkg::OP_MOVE_GO) begin
        go_axis_ff <= axis;
        go_asym_ff <= 1'b0;
        go_rate_ff <= accel_ff[axis];
      end
    end
  end

  assign O_MOVE_GO    = go_ff;
  assign O_MOVE_AXIS  = go_axis_ff;
  assign O_MOVE_ASYM  = go_asym_ff;
  assign O_MOVE_DECEL = go_rate_ff;

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SRST);

  a_pt_cap: assert property (pt_cnt_ff <= `RTD_MAX_PTS)
    else $error("breakpoint count above table limit");
  a_frac_range: assert property (exec && op == rtd_pkg::OP_BKPT_DEF &&
      acc_frac > `RTD_FRAC_ONE |=> refused_ff && $stable(pt_cnt_ff))
    else $error("out of range fraction was stored");
  a_end_close: assert property (exec && def_open_ff && op == rtd_pkg::OP_TBL_END
      |=> !def_open_ff && open_tbl_ff == 3'h0)
    else $error("end did not close definition");
  a_begin_clear: assert property (exec && ok && op == rtd_pkg::OP_TBL_BEGIN
      |=> def_open_ff && pt_cnt_ff == 5'h00 && size_ff[$past(tix)] == 5'h00)
    else $error("begin did not restart table");
  a_open_block: assert property (exec && def_open_ff &&
      op != rtd_pkg::OP_BKPT_DEF && op != rtd_pkg::OP_TBL_END
      |=> refused_ff && $stable(inv_ff) && def_open_ff)
    else $error("command acted during open definition");
  a_entry_empty: assert property (exec && ok && op == rtd_pkg::OP_ENTRY_Q &&
      idx > size_ff[tix] |-> ##2 resp_valid_ff && resp_empty_ff)
    else $error("missing entry not flagged empty");
  a_dir_invert: assert property (exec && ok && op == rtd_pkg::OP_DIR_INVERT
      |=> (inv_ff & $past(mask)) == $past(mask) &&
          (inv_ff & ~$past(mask)) == ($past(inv_ff) & ~$past(mask)))
    else $error("invert touched wrong axes");
  a_dir_output: assert property (inv_ff[0] == 1'b0 && $stable(inv_ff)
      |=> O_DIR[0] == $past(I_AXIS_NEG[0]))
    else $error("direction output wrong polarity");
  a_decel_track: assert property (exec && ok && op == rtd_pkg::OP_ACCEL_SET
      |=> decel_ff[$past(axis)] == $past(arg0_ff[RATE_W-1:0]))
    else $error("decel did not follow accel set");
  a_asym_rate: assert property (exec && ok && op == rtd_pkg::OP_ASYM_GO
      |=> O_MOVE_GO && O_MOVE_ASYM && O_MOVE_DECEL == $past(decel_ff[axis]))
    else $error("asymmetric start used wrong rate");
  a_decel_range: assert property (decel_ff[0] != '0 &&
      decel_ff[0] <= `RTD_RATE_MAX)
    else $error("decel rate out of range");
endmodule // rtd_ramp_dir_decel

/* File: dv/rtd_host_model.sv */
`timescale 1ns/1ps
module rtd_host_model (
  input  wire logic        i_clk,         // Bus clock
  output logic      [4:0]  o_address,     // Byte address
  output logic             o_read,        // Read request
  output logic             o_write,       // Write request
  output logic      [31:0] o_writedata,   // Write data
  input  wire logic [31:0] i_readdata,    // Read data
  input  wire logic        i_waitrequest  // Stall
);
  initial begin
    o_address   = 5'h00;
    o_read      = 1'b0;
    o_write     = 1'b0;
    o_writedata = 32'h0000_0000;
  end

  // Stall and data taken at the rising edge, before that edge updates them
  task automatic hold(output logic [31:0] d);
    logic w;
    int   n;
    w = 1'b1;
    n = 0;
    while (w !== 1'b0) begin
      @(posedge i_clk);
      w = i_waitrequest;
      d = i_readdata;
      n++;
      if (n > 64) begin
        rtd_ramp_dir_decel_tb.failures++;
        rtd_ramp_dir_decel_tb.stop_test();
      end
    end
    o_read  <= 1'b0;
    o_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    logic [31:0] d;
    @(posedge i_clk);
    o_address   <= a;
    o_writedata <= v;
    o_write     <= 1'b1;
    hold(d);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge i_clk);
    o_address <= a;
    o_read    <= 1'b1;
    hold(d);
  endtask
endmodule // rtd_host_model

/* File: dv/rtd_ramp_dir_decel_tb.sv */
`timescale 1ns/1ps
module rtd_ramp_dir_decel_tb;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [3:0]  neg = 4'h0;
  logic [4:0]  addr;
  logic        rd_en;
  logic        wr_en;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        stall;
  logic [3:0]  dir;
  logic        go;
  logic [1:0]  maxis;
  logic        asym;
  logic [22:0] mdecel;
  int          failures = 0;
  int          num_checks = 0;
  int unsigned tq[1:4][$];
  int unsigned decel[4];
  int unsigned accel[4];
  logic [3:0]  inv = 4'h0;
  logic [31:0] s;
  logic [31:0] d;
  int unsigned v;
  int unsigned r;

  always #12.5 clk = ~clk;

  rtd_ramp_dir_decel DUT (
    .I_REF_CLK(clk), .I_SRST(srst), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd_en),
    .I_AVS_WRITE(wr_en), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(4'hF),
    .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(stall), .I_AXIS_NEG(neg), .O_DIR(dir),
    .O_MOVE_GO(go), .O_MOVE_AXIS(maxis), .O_MOVE_ASYM(asym), .O_MOVE_DECEL(mdecel));

  rtd_host_model host (
    .i_clk(clk), .o_address(addr), .o_read(rd_en), .o_write(wr_en),
    .o_writedata(wdata), .i_readdata(rdata), .i_waitrequest(stall));

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (failures == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmd(rtd_pkg::rtd_op_type op, logic [3:0] m, logic [1:0] a, logic [2:0] t,
                     logic [4:0] i);
    int n;
    n = 0;
    host.wr(5'h00, {11'h000, i, 1'b0, t, 2'b00, a, m, op});
    do begin
      host.rd(5'h0C, s);
      n++;
      if (n > 50) begin
        failures++;
        stop_test();
      end
    end while (s[0] !== 1'b0);
  endtask

  // Refusal flag is sticky, so clear it after each look that finds it set
  task automatic ref_chk(logic e);
    host.rd(5'h0C, s);
    chk("refused", {31'h0, e}, {31'h0, s[5]});
    if (s[5] === 1'b1) host.wr(5'h0C, 32'h0000_0020);
  endtask

  task automatic resp_chk(string n, logic [31:0] e);
    host.rd(5'h10, d);
    chk(n, e, d);
  endtask

  task automatic bkpt(int unsigned ac, int unsigned vl);
    host.wr(5'h04, ac);
    host.wr(5'h08, vl);
    cmd(rtd_pkg::OP_BKPT_DEF, 4'h0, 2'h0, 3'h0, 5'h00);
  endtask

  task automatic entry_chk(int t, int i);
    cmd(rtd_pkg::OP_ENTRY_Q, 4'h0, 2'h0, 3'(t), 5'(i));
    host.rd(5'h0C, s);
    chk("entry_flags", {30'h0, 1'b1, i > tq[t].size()}, {30'h0, s[7:6]});
    resp_chk("entry", i > tq[t].size() ? 0 : tq[t][i-1]);
  endtask

  task automatic state_chk();
    neg <= 4'($urandom);
    @(posedge clk);
    @(posedge clk);
    #1;
    chk("dir_out", {28'h0, inv ^ neg}, {28'h0, dir});
    host.rd(5'h14, d);
    chk("dir_reg", {28'h0, inv}, d);
    for (int a = 0; a < 4; a++) begin
      cmd(rtd_pkg::OP_DIR_Q, 4'h0, 2'(a), 3'h0, 5'h00);
      resp_chk("polarity", {31'h0, inv[a]});
      cmd(rtd_pkg::OP_DECEL_Q, 4'h0, 2'(a), 3'h0, 5'h00);
      resp_chk("decel", decel[a]);
    end
  endtask

  task automatic start(rtd_pkg::rtd_op_type op, int a);
    logic y;
    y = (op == rtd_pkg::OP_ASYM_GO);
    host.wr(5'h00, {22'h0, 2'(a), 4'h0, op});
    @(posedge clk);
    #1;
    chk("move", {5'h00, 1'b1, y, 2'(a), 23'(y ? decel[a] : accel[a])},
        {5'h00, go, asym, maxis, mdecel});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int a = 0; a < 4; a++) begin
      decel[a] = 32'h0003_0D40;
      accel[a] = 32'h0003_0D40;
    end
    r = $urandom(32'h27d6_fe27);
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    host.rd(5'h0C, s);
    chk("status", 32'h0000_0000, s);
    state_chk();
    // Full table with overflow; foreign commands while open
    cmd(rtd_pkg::OP_TBL_BEGIN, 4'h0, 2'h0, 3'h2, 5'h00);
    host.rd(5'h0C, s);
    chk("status", 32'h0000_000A, s);
    cmd(rtd_pkg::OP_DIR_INVERT, 4'hF, 2'h0, 3'h0, 5'h00);
    ref_chk(1'b1);
    host.wr(5'h04, 32'h0000_0005);
    cmd(rtd_pkg::OP_DECEL_SET, 4'h0, 2'h0, 3'h0, 5'h00);
    ref_chk(1'b1);
    // Fractions just above full scale, refused while the table has room
    bkpt(32'h0000_8001, 32'h0000_0000);
    ref_chk(1'b1);
    bkpt(32'h0000_0000, 32'h0000_8001);
    ref_chk(1'b1);
    v = 0;
    for (int i = 1; i <= 26; i++) begin
      r = $urandom_range(32'h0000_8000, 0);
      v = (i >= 25) ? 32'h0000_8000 : v + $urandom_range(1000, 0);
      bkpt(r, v);
      ref_chk(i == 26);
      if (i <= 25) tq[2].push_back({v[15:0], r[15:0]});
    end
    bkpt(32'h0000_8001, v);
    ref_chk(1'b1);
    cmd(rtd_pkg::OP_TBL_END, 4'h0, 2'h0, 3'h0, 5'h00);
    host.rd(5'h0C, s);
    chk("status", 32'h0000_0000, s);
    state_chk();
    cmd(rtd_pkg::OP_SIZE_Q, 4'h0, 2'h0, 3'h2, 5'h00);
    resp_chk("size", 32'd25);
    for (int k = 0; k < 4; k++) entry_chk(2, $urandom_range(25, 1));
    entry_chk(2, 25);
    cmd(rtd_pkg::OP_ENTRY_Q, 4'h0, 2'h0, 3'h2, 5'h1A);
    ref_chk(1'b1);
    // Short tables; table 2 is replaced by a smaller one
    for (int t = 2; t <= 4; t++) begin
      cmd(rtd_pkg::OP_TBL_BEGIN, 4'h0, 2'h0, 3'(t), 5'h00);
      tq[t].delete();
      for (int i = 0; i < t; i++) begin
        bkpt(i * 4096, i * 8192);
        tq[t].push_back({16'(i * 8192), 16'(i * 4096)});
      end
      cmd(rtd_pkg::OP_TBL_END, 4'h0, 2'h0, 3'h0, 5'h00);
      cmd(rtd_pkg::OP_SIZE_Q, 4'h0, 2'h0, 3'(t), 5'h00);
      resp_chk("size", t);
      entry_chk(t, t);
      entry_chk(t, t + 1);
    end
    cmd(rtd_pkg::OP_TBL_BEGIN, 4'h0, 2'h0, 3'h0, 5'h00);
    ref_chk(1'b1);
    cmd(rtd_pkg::OP_TBL_BEGIN, 4'h0, 2'h0, 3'h5, 5'h00);
    ref_chk(1'b1);
    // Direction polarity with random axis masks
    for (int k = 0; k < 6; k++) begin
      r = $urandom_range(15, 0);
      cmd(k[0] ? rtd_pkg::OP_DIR_NORMAL : rtd_pkg::OP_DIR_INVERT, 4'(r), 2'h0, 3'h0, 5'h00);
      inv = k[0] ? inv & ~4'(r) : inv | 4'(r);
      state_chk();
    end
    // Rates at both range ends, refusals, accel copying into decel
    for (int a = 0; a < 4; a++) begin
      r = a == 0 ? 1 : a == 1 ? 32'h007A_1200 : $urandom_range(32'h007A_1200, 1);
      host.wr(5'h04, r);
      cmd(rtd_pkg::OP_DECEL_SET, 4'h0, 2'(a), 3'h0, 5'h00);
      decel[a] = r;
    end
    host.wr(5'h04, 32'h0000_0000);
    cmd(rtd_pkg::OP_DECEL_SET, 4'h0, 2'h2, 3'h0, 5'h00);
    ref_chk(1'b1);
    host.wr(5'h04, 32'h007A_1201);
    cmd(rtd_pkg::OP_DECEL_SET, 4'h0, 2'h2, 3'h0, 5'h00);
    ref_chk(1'b1);
    r = $urandom_range(32'h007A_1200, 1);
    host.wr(5'h04, r);
    cmd(rtd_pkg::OP_ACCEL_SET, 4'h0, 2'h3, 3'h0, 5'h00);
    accel[3] = r;
    decel[3] = r;
    state_chk();
    start(rtd_pkg::OP_ASYM_GO, 0);
    start(rtd_pkg::OP_MOVE_GO, 0);
    start(rtd_pkg::OP_ASYM_GO, 3);
    // Reset in mid-run restores rates, polarities and empty tables
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    inv = 4'h0;
    for (int a = 0; a < 4; a++) begin
      decel[a] = 32'h0003_0D40;
      accel[a] = 32'h0003_0D40;
    end
    for (int t = 1; t <= 4; t++) tq[t].delete();
    state_chk();
    cmd(rtd_pkg::OP_SIZE_Q, 4'h0, 2'h0, 3'h2, 5'h00);
    resp_chk("size", 32'h0000_0000);
    entry_chk(2, 1);
    stop_test();
  end
endmodule // rtd_ramp_dir_decel_tb
